// ---- design/scs_clock_select.sv ----
`timescale 1ns/1ns
// Summary of operation
// - internal fast oscillator, fixed 8MHz, fast source
// - slow 32kHz oscillator always runs, no disable
// - fast/slow bit plus divider field pick clock
// - offer fast/2 through fast/64 as choices
// - slow selected stops fast oscillator and taps
// - one 8-bit mode register, documented reset
// - fast ready low asleep, high after 1024
// - slow ready low asleep, high 1-2 ticks
module scs_clock_select
    import scs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // power mode requests from the core, same clock
    input wire logic sleep_i,
    input wire logic idle0_i,
    // clock outputs as one-cycle ticks, fast run and idle enable as levels
    output logic core_tick_o,
    output logic slow_tick_o,
    output scs_taps_t fast_taps_o,
    output logic fast_run_o,
    output logic idle_enable_o
);
    logic [12:0] slow_gap_r;   // cycles since last slow tick, check helper
    logic [12:0] wake_wait_r;  // awake cycles with slow ready still low, check helper

    logic [2:0] divider_select_r;  // divider code
    logic fast_slow_select_r;      // 1 forces undivided fast clock
    logic idle_enable_bit_r;       // idle enable, registered onto idle_enable_o
    logic fast_osc_ready_r;        // fast oscillator stable
    logic slow_osc_ready_r;        // slow oscillator stable
    logic [FAST_READY_W-1:0] rdy_cnt_r;  // fast ticks since restart
    logic [5:0] div_cnt_r;         // fast prescaler
    logic fast_tick;               // raw fast oscillator tick
    logic slow_tick;               // raw slow oscillator tick
    logic src_slow;                // slow clock chosen
    logic fast_run;                // fast oscillator enable
    logic [5:0] div_tick;          // divided fast ticks
    logic core_nxt;                // next core tick
    logic [7:0] mode_rd;           // mode register read view
    logic wb_req;                  // new bus request this cycle

    // slow clock source when fast bit clear and code 0 or 1
    always_comb begin
        src_slow = !fast_slow_select_r &&
            (divider_select_r == DIV_SLOW_A || divider_select_r == DIV_SLOW_B);
    end

    // fast oscillator runs unless asleep, in idle0 or slow selected
    always_comb begin
        fast_run = !sleep_i && !idle0_i && !src_slow;
    end

    // fast oscillator, stoppable
    scs_rc_osc #(
        .PERIOD(FAST_OSC_CYC),
        .CW(12)
    ) u_fast (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(fast_run),
        .tick_o(fast_tick)
    );

    // slow oscillator, enable tied on so no register can stop it
    scs_rc_osc #(
        .PERIOD(SLOW_OSC_CYC),
        .CW(12)
    ) u_slow (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(1'b1),
        .tick_o(slow_tick)
    );

    // fast prescaler advances on each fast tick
    always_ff @(posedge clk_i) begin
        if (rst_i || !fast_run) begin
            div_cnt_r <= '0;
        end else if (fast_tick) begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    // divided tick k fires when the low k prescaler bits are all ones
    genvar k;
    generate
        for (k = 1; k <= 6; k++) begin : g_div
            assign div_tick[k-1] = fast_tick && (&div_cnt_r[k-1:0]);
        end
    endgenerate

    // core clock multiplexer
    always_comb begin
        core_nxt = 1'b0;
        if (fast_slow_select_r) begin
            core_nxt = fast_tick;
        end else begin
            case (divider_select_r)
                DIV_SLOW_A, DIV_SLOW_B: core_nxt = slow_tick;
                DIV_64: core_nxt = div_tick[5];
                DIV_32: core_nxt = div_tick[4];
                DIV_16: core_nxt = div_tick[3];
                DIV_8: core_nxt = div_tick[2];
                DIV_4: core_nxt = div_tick[1];
                default: core_nxt = div_tick[0];  // code 7 picks fast/2
            endcase
        end
    end

    // registered clock outputs; fast taps go quiet when stopped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_tick_o <= 1'b0;
            slow_tick_o <= 1'b0;
            fast_taps_o <= '0;
            fast_run_o <= 1'b0;
        end else begin
            core_tick_o <= core_nxt;
            slow_tick_o <= slow_tick;
            fast_taps_o.fast <= fast_tick && fast_run;
            fast_taps_o.div <= fast_run ? div_tick : 6'h00;
            fast_run_o <= fast_run;
        end
    end

    // fast ready: cleared while stopped, set after 1024 ticks
    always_ff @(posedge clk_i) begin
        if (rst_i || !fast_run) begin
            rdy_cnt_r <= '0;
            fast_osc_ready_r <= 1'b0;
        end else if (fast_tick && !fast_osc_ready_r) begin
            rdy_cnt_r <= rdy_cnt_r + 1'b1;
            if (rdy_cnt_r == FAST_READY_W'(FAST_READY_TICKS - 1)) begin
                fast_osc_ready_r <= 1'b1;
            end
        end
    end

    // slow ready: low in sleep, set on first slow tick after it
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep_i) begin
            slow_osc_ready_r <= 1'b0;
        end else if (slow_tick) begin
            slow_osc_ready_r <= 1'b1;
        end
    end

    // bus request not yet answered
    always_comb begin
        wb_req = cyc_i && stb_i && !ack_o;
    end

    // mode register writable fields, low byte lane only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divider_select_r <= DIV_RST;
            idle_enable_bit_r <= IDLE_EN_RST;
            fast_slow_select_r <= FSS_RST;
        end else if (wb_req && we_i && sel_i[0] && adr_i == ADR_MODE) begin
            divider_select_r <= dat_i[MODE_DIV_LSB +: 3];
            idle_enable_bit_r <= dat_i[MODE_IDLE_EN];
            fast_slow_select_r <= dat_i[MODE_FSS];
        end
    end

    // read view of the mode register, bit 4 reads zero
    always_comb begin
        mode_rd = 8'h00;
        mode_rd[MODE_DIV_LSB +: 3] = divider_select_r;
        mode_rd[MODE_SLOW_RDY] = slow_osc_ready_r;
        mode_rd[MODE_FAST_RDY] = fast_osc_ready_r;
        mode_rd[MODE_IDLE_EN] = idle_enable_bit_r;
        mode_rd[MODE_FSS] = fast_slow_select_r;
    end

    // ack one cycle after request; reads decoded, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req;
            if (wb_req && !we_i && adr_i == ADR_MODE) begin
                dat_o <= {24'h000000, mode_rd};
            end else if (wb_req && !we_i && adr_i == ADR_STAT) begin
                dat_o <= {30'h0000_0000, src_slow, fast_run};
            end else if (wb_req) begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // idle enable drives the power controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_enable_o <= IDLE_EN_RST;
        end else begin
            idle_enable_o <= idle_enable_bit_r;
        end
    end

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    a_mode_reset_val: assert property (@(posedge clk_i)
        $past(rst_i) |-> divider_select_r == 3'h0 && fast_slow_select_r && idle_enable_bit_r
            && !fast_osc_ready_r && !slow_osc_ready_r)
        else $error("mode register reset value wrong");

    a_mode_write_takes: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_req && we_i && sel_i[0] && adr_i == 4'h0) |=>
            divider_select_r == $past(dat_i[7:5]) && fast_slow_select_r == $past(dat_i[0]))
        else $error("mode register write lost");

    // check helper: cycles between slow ticks, saturating so a stall stays visible
    always_ff @(posedge clk_i) begin
        if (rst_i || slow_tick) begin
            slow_gap_r <= '0;
        end else if (slow_gap_r != '1) begin
            slow_gap_r <= slow_gap_r + 1'b1;
        end
    end

    // check helper: how long slow ready has stayed low since reset or wake
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep_i || slow_osc_ready_r) begin
            wake_wait_r <= '0;
        end else if (wake_wait_r != '1) begin
            wake_wait_r <= wake_wait_r + 1'b1;
        end
    end

    a_slow_never_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        slow_gap_r <= 13'(SLOW_OSC_CYC))
        else $error("slow oscillator stopped");

    a_fast_taps_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        src_slow |=> fast_taps_o == '0 && !fast_run_o)
        else $error("fast taps active with slow clock selected");

    a_fast_ready_count: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fast_osc_ready_r) |-> $past(rdy_cnt_r) == 10'h3FF && $past(fast_tick))
        else $error("fast ready rose at wrong count");

    a_fast_ready_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (sleep_i || idle0_i) |=> !fast_osc_ready_r)
        else $error("fast ready high in sleep or idle0");

    a_slow_ready_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_wait_r <= 13'(2 * SLOW_OSC_CYC))
        else $error("slow ready late after wake");

    a_slow_ready_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(slow_osc_ready_r) |-> $past(slow_tick) && !$past(sleep_i))
        else $error("slow ready rose without a slow tick");

    a_slow_src_core: assert property (@(posedge clk_i) disable iff (rst_i)
        (!fast_slow_select_r && divider_select_r[2:1] == 2'b00) |=> core_tick_o == $past(slow_tick))
        else $error("core clock not following slow clock");

    a_fast_src_core: assert property (@(posedge clk_i) disable iff (rst_i)
        fast_slow_select_r |=> core_tick_o == $past(fast_tick))
        else $error("core clock not following fast clock");
endmodule

// ---- design/scs_rc_osc.sv ----
`timescale 1ns/1ns
module scs_rc_osc
    import scs_pkg::*;
#(
    parameter int PERIOD = 12,
    parameter int CW = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic tick_o
);
    logic [CW-1:0] cnt_r;  // cycles since last tick

    // period counter, held at zero while stopped
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= '0;
        end else if (cnt_r == CW'(PERIOD - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // one-cycle tick at the end of each period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= run_i && (cnt_r == CW'(PERIOD - 1));
        end
    end
endmodule

// ---- shared/scs_pkg.sv ----
package scs_pkg;
    // system clock rate and oscillator nominal rates
    localparam int CLK_HZ = 100_000_000;
    localparam int FAST_OSC_HZ = 8_000_000;
    localparam int SLOW_OSC_HZ = 32_000;
    // oscillator periods in system clock cycles
    localparam int FAST_OSC_CYC = CLK_HZ / FAST_OSC_HZ;
    localparam int SLOW_OSC_CYC = CLK_HZ / SLOW_OSC_HZ;
    // fast oscillator ticks counted before the fast ready flag rises
    localparam int FAST_READY_TICKS = 1024;
    localparam int FAST_READY_W = 10;

    // register byte addresses
    localparam logic [3:0] ADR_MODE = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;

    // clock mode register field positions
    localparam int MODE_DIV_LSB = 5;
    localparam int MODE_SLOW_RDY = 3;
    localparam int MODE_FAST_RDY = 2;
    localparam int MODE_IDLE_EN = 1;
    localparam int MODE_FSS = 0;

    // clock mode register reset values
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic IDLE_EN_RST = 1'b1;
    localparam logic FSS_RST = 1'b1;

    // divider select codes
    localparam logic [2:0] DIV_SLOW_A = 3'h0;
    localparam logic [2:0] DIV_SLOW_B = 3'h1;
    localparam logic [2:0] DIV_64 = 3'h2;
    localparam logic [2:0] DIV_32 = 3'h3;
    localparam logic [2:0] DIV_16 = 3'h4;
    localparam logic [2:0] DIV_8 = 3'h5;
    localparam logic [2:0] DIV_4 = 3'h6;
    localparam logic [2:0] DIV_2 = 3'h7;  // fast/2

    // fast clock taps handed to peripherals
    typedef struct packed {
        logic [5:0] div;  // div[k-1]: one tick per 2**k fast ticks
        logic fast;       // undivided fast tick
    } scs_taps_t;
endpackage

// ---- verification/scs_clock_select_test.sv ----
`timescale 1ns/1ns
module scs_clock_select_test
    import scs_pkg::*;
;
    // bench clock, reset and bus drive
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic sleep_i = 1'b0;
    logic idle0_i = 1'b0;
    // design outputs
    logic [31:0] dat_o;
    logic ack_o, core_tick_o, slow_tick_o, fast_run_o, idle_enable_o;
    scs_taps_t fast_taps_o;
    // bookkeeping
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    int p;
    logic [31:0] rd;
    // core tick period for each divider code
    int exp_p[8] = '{SLOW_OSC_CYC, SLOW_OSC_CYC, FAST_OSC_CYC * 64, FAST_OSC_CYC * 32,
                     FAST_OSC_CYC * 16, FAST_OSC_CYC * 8, FAST_OSC_CYC * 4, FAST_OSC_CYC * 2};

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    scs_clock_select dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sleep_i(sleep_i), .idle0_i(idle0_i), .core_tick_o(core_tick_o),
        .slow_tick_o(slow_tick_o), .fast_taps_o(fast_taps_o), .fast_run_o(fast_run_o),
        .idle_enable_o(idle_enable_o)
    );

    // compare and count
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // one classic wishbone cycle; read data lands in rd
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    // cycles between two ticks: 0 core, 1 slow, 2 fast/64 tap
    task meas(input int sel, output int n);
        n = 0;
        do @(posedge clk_i);
        while ((sel == 1 ? slow_tick_o : sel == 2 ? fast_taps_o.div[5] : core_tick_o) !== 1'b1);
        do begin
            @(posedge clk_i);
            n++;
        end while ((sel == 1 ? slow_tick_o : sel == 2 ? fast_taps_o.div[5] : core_tick_o) !== 1'b1);
    endtask

    // counts and verdict
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard, well above the expected run length
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 80000) begin
            error_cnt++;
            complete_run;
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, ready flags masked
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("mode_rst", rd & 32'hFFFF_FFF3, 32'h03);
        chk("idle_out_rst", idle_enable_o, 1);
        chk("fast_run_rst", fast_run_o, 1);
        wb(1'b0, ADR_STAT, 8'h00, 4'h1);
        chk("stat_rst", rd, 32'h1);
        wb(1'b0, 4'h8, 8'h00, 4'h1);
        chk("unmapped_rd", rd, 32'h0);
        $display("test reset done");
        // read-only bits, lane-off and unmapped writes
        wb(1'b1, ADR_MODE, 8'hFF, 4'h1);
        wb(1'b1, ADR_MODE, 8'h00, 4'h0);
        wb(1'b1, 4'h8, 8'h00, 4'h1);
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("mode_rw", rd & 32'hFFFF_FFF3, 32'hE3);
        $display("test access done");
        // every divider code with the fast/slow bit clear
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, ADR_MODE, {c[2:0], 5'h02}, 4'h1);
            meas(1'b0, p);
            meas(1'b0, p);
            chk("core_period", p, exp_p[c]);
            if (c < 2) begin
                chk("taps_off", {fast_run_o, fast_taps_o}, 32'h0);
                wb(1'b0, ADR_STAT, 8'h00, 4'h1);
                chk("stat_slow", rd, 32'h2);
            end
        end
        $display("test select done");
        // fast stops, then restarts and counts to ready
        wb(1'b1, ADR_MODE, 8'h00, 4'h1);
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("fast_rdy_off", rd[2], 0);
        wb(1'b1, ADR_MODE, 8'h01, 4'h1);
        meas(1'b0, p);
        meas(1'b0, p);
        chk("fss_period", p, FAST_OSC_CYC);
        chk("idle_out", idle_enable_o, 0);
        repeat (11000) @(posedge clk_i);
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("fast_rdy_early", rd[3:2], 2'h2);
        repeat (2500) @(posedge clk_i);
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("fast_rdy_set", rd[3:2], 2'h3);
        meas(2, p);
        meas(2, p);
        chk("tap64_period", p, FAST_OSC_CYC * 64);
        $display("test ready done");
        // idle0 drops the fast flag
        idle0_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("fast_rdy_idle0", rd[2], 0);
        idle0_i <= 1'b0;
        // sleep drops both flags, slow keeps ticking
        sleep_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("rdy_sleep", rd[3:2], 2'h0);
        meas(1'b1, p);
        chk("slow_period", p, SLOW_OSC_CYC);
        sleep_i <= 1'b0;
        repeat (SLOW_OSC_CYC + 2) @(posedge clk_i);
        wb(1'b0, ADR_MODE, 8'h00, 4'h1);
        chk("slow_rdy_wake", rd[3], 1);
        $display("test power done");
        complete_run;
    end
endmodule
